// ### dv/hip_assertions.sv
// checks on the pins between the host controller and the device port
`timescale 1ns/100ps
module hip_assertions (
    input wire logic clock,
    input wire logic reset,
    input wire logic host_port_select_n,
    input wire logic host_port_address_latch,
    input wire logic host_port_read_strobe_n,
    input wire logic host_port_write_strobe_n,
    input wire logic host_port_acknowledge_n,
    input wire logic host_bus_oe,
    input wire logic dev_bus_oe,
    input wire logic [15:0] host_port_shared_bus
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_ack_pulse_short: assert property (
        $rose(host_port_acknowledge_n) |=> ##[0:1] !host_port_acknowledge_n)
        else $error("acknowledge stayed deasserted too long");
    a_ack_after_req: assert property (
        ($fell(host_port_write_strobe_n) || $fell(host_port_read_strobe_n))
        && !host_port_select_n |-> ##[2:3] host_port_acknowledge_n)
        else $error("request not answered after sync and access cycles");
    a_read_data_driven: assert property (
        !host_port_read_strobe_n && $fell(host_port_acknowledge_n) |-> dev_bus_oe)
        else $error("read finished without device driving the bus");
    a_no_bus_fight: assert property (
        !(host_bus_oe && dev_bus_oe))
        else $error("both ends drive the shared bus");
    a_write_no_drive: assert property (
        !host_port_write_strobe_n |-> !dev_bus_oe)
        else $error("device drives the bus during a write");
    a_latch_held: assert property (
        $rose(host_port_address_latch) |=> host_port_address_latch[*4])
        else $error("address latch pulse too short");
    a_addr_when_acked: assert property (
        $fell(host_port_address_latch) |-> !host_port_acknowledge_n && host_bus_oe)
        else $error("address latched while not acknowledged");
    a_sel_with_strobe: assert property (
        !host_port_read_strobe_n || !host_port_write_strobe_n |-> !host_port_select_n)
        else $error("strobe without select");
    a_wait_for_ack: assert property (
        $fell(host_port_read_strobe_n) || $fell(host_port_write_strobe_n)
        |-> !host_port_acknowledge_n)
        else $error("access started while device busy");
    a_wdata_stable: assert property (
        !host_port_write_strobe_n && !$past(host_port_write_strobe_n)
        |-> $stable(host_port_shared_bus))
        else $error("write data changed during the strobe");
endmodule

// ### dv/hip_bench.sv
// self-checking bench: apb host controller facing the device port
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module hip_bench;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] boot_mode = hip_pkg::BOOT_FROM_PORT;
    logic core_req = 1'b0;
    logic core_we = 1'b0;
    logic [13:0] core_addr = 14'h0000;
    logic [15:0] core_wdata = 16'h0000;
    logic core_ack;
    logic core_run;
    logic [15:0] core_rdata;
    logic [7:0] memory_overlay_select;
    logic [31:0] q;
    logic err;
    int failures = 0;
    int n_compared = 0;
    int busy_run = 0;
    int busy_len = 0;

    hip_if port ();
    hip_device i_hip_device (.clock(clock), .reset(reset), .port(port),
        .boot_mode(boot_mode), .core_req(core_req), .core_we(core_we),
        .core_addr(core_addr), .core_wdata(core_wdata), .core_ack(core_ack),
        .core_rdata(core_rdata), .core_run(core_run),
        .memory_overlay_select(memory_overlay_select));
    hip_host i_hip_host (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port(port));
    hip_assertions i_hip_assertions (.clock(clock), .reset(reset),
        .host_port_select_n(port.host_port_select_n),
        .host_port_address_latch(port.host_port_address_latch),
        .host_port_read_strobe_n(port.host_port_read_strobe_n),
        .host_port_write_strobe_n(port.host_port_write_strobe_n),
        .host_port_acknowledge_n(port.host_port_acknowledge_n),
        .host_bus_oe(port.host_bus_oe), .dev_bus_oe(port.dev_bus_oe),
        .host_port_shared_bus(port.host_port_shared_bus));

    always #10 clock = ~clock;

    // length of the last acknowledge-high stretch, so read timing is judged too
    always @(posedge clock) begin
        if (port.host_port_acknowledge_n === 1'b1) begin
            busy_run <= busy_run + 1;
        end else if (busy_run != 0) begin
            busy_len <= busy_run;
            busy_run <= 0;
        end
    end

    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // bounded waits: a hang counts as a mismatch and ends the run
    task give_up;
        failures++;
        complete_run();
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        @(posedge clock);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clock);
        end
        if (n == 20) give_up();
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // busy must clear before the next command is accepted
    task host_op(input logic [1:0] cmd, input logic [15:0] w);
        int n;
        apb(1'b1, hip_pkg::HOST_WDATA_OFF, {16'h0000, w});
        apb(1'b1, hip_pkg::HOST_CMD_OFF, {30'h0, cmd});
        q = 32'h1;
        n = 0;
        while (q[0] !== 1'b0 && n < 100) begin
            apb(1'b0, hip_pkg::HOST_STATUS_OFF, 32'h0);
            n++;
        end
        if (n == 100) give_up();
    endtask

    task host_rd(input logic [15:0] e, input string nm);
        host_op(hip_pkg::CMD_READ, 16'h0000);
        apb(1'b0, hip_pkg::HOST_RDATA_OFF, 32'h0);
        `CHK(nm, e, q[15:0])
    endtask

    task core_op(input logic we, input logic [13:0] a, input logic [15:0] d,
                 input logic [15:0] e, input string nm);
        int n;
        @(posedge clock);
        core_req <= 1'b1;
        core_we <= we;
        core_addr <= a;
        core_wdata <= d;
        n = 0;
        @(posedge clock);
        while (core_ack !== 1'b1 && n < 20) begin
            n++;
            @(posedge clock);
        end
        if (n == 20) give_up();
        core_req <= 1'b0;
        if (!we) `CHK(nm, e, core_rdata)
    endtask

    task boot_load;
        host_op(hip_pkg::CMD_LATCH, 16'h4000);
        host_op(hip_pkg::CMD_WRITE, 16'h1234);
        `CHK("run half", 1'b0, core_run)
        host_op(hip_pkg::CMD_WRITE, 16'h0056);
        `CHK("run loaded", 1'b1, core_run)
        host_op(hip_pkg::CMD_LATCH, 16'h4000);
        host_rd(16'h1234, "prog hi");
        host_rd(16'h0056, "prog lo");
    endtask

    task data_block;
        host_op(hip_pkg::CMD_LATCH, 16'h0010);
        for (int i = 0; i < 3; i++)
            host_op(hip_pkg::CMD_WRITE, 16'ha001 + 16'(i));
        for (int i = 0; i < 3; i++)
            core_op(1'b0, 14'h0010 + 14'(i), 16'h0, 16'ha001 + 16'(i), "block");
        core_op(1'b0, hip_pkg::CTRL_REG_ADDR, 16'h0, 16'h0013, "ctrl");
    endtask

    task core_ctrl;
        core_op(1'b1, 14'h0020, 16'hbeef, 16'h0, "");
        core_op(1'b1, hip_pkg::CTRL_REG_ADDR, 16'h0020, 16'h0, "");
        host_rd(16'hbeef, "core set addr");
    endtask

    task reg_guard;
        host_op(hip_pkg::CMD_LATCH, 16'h3fe7);
        host_op(hip_pkg::CMD_WRITE, 16'h4000);
        core_op(1'b0, hip_pkg::SYS_REG_ADDR, 16'h0, 16'h0000, "sys reg");
        host_op(hip_pkg::CMD_LATCH, 16'h3fe0);
        host_rd(16'h0000, "ctrl readback");
        `CHK("long read len", 2, busy_len)
    endtask

    task short_read;
        core_op(1'b1, hip_pkg::SYS_REG_ADDR, 16'h4000, 16'h0, "");
        core_op(1'b0, hip_pkg::SYS_REG_ADDR, 16'h0, 16'h4000, "sys bit");
        host_op(hip_pkg::CMD_LATCH, 16'h0011);
        host_rd(16'ha002, "short read");
        `CHK("short read len", 1, busy_len)
    endtask

    task overlay;
        host_op(hip_pkg::CMD_LATCH, 16'h80a5);
        `CHK("overlay", 8'ha5, memory_overlay_select)
        host_op(hip_pkg::CMD_LATCH, 16'h8000);
        `CHK("overlay zero", 8'h00, memory_overlay_select)
    endtask

    // mid-run reset with a non-port boot strap: the core must start at once
    task boot_other;
        @(posedge clock);
        boot_mode <= 3'h0;
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK("run direct", 1'b1, core_run)
    endtask

    initial begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK("run held", 1'b0, core_run)
        boot_load();
        data_block();
        core_ctrl();
        reg_guard();
        short_read();
        overlay();
        // unmapped controller offset is refused
        apb(1'b0, 12'h010, 32'h0);
        `CHK("apb err", 1'b1, err)
        boot_other();
        complete_run();
    end
endmodule

// ### hdl/hip_device.sv
// device end of the host memory access port, with on-chip memories
// What this block does
// - host reaches memories, one access per data word, two per program word
// - host cannot write mapped control registers
// - bit15 set: bits 7:0 are overlay
// - bit15 clear: 13:0 address, 14 space
// - software keeps both overlay fields zero
// - shared 16-bit bus, 24-bit program words
// - asynchronous strobes, core keeps running
// - address advances after every completed word
// - host drives address only while acknowledged
// - latch falling edge or select edge captures
// - host asserts select with read/write
// - two sync cycles, one access cycle, two for reads while system bit 14 is clear
// - host checks acknowledge around each access
// - control register mapped in data memory
// - host cannot read back latched address
// - system bit 14 picks short-read timing
// - boot straps c1 b0 a1 boot port
// - core held until program word 0 written
`timescale 1ns/100ps
module hip_device (
    input wire logic clock,
    input wire logic reset,
    hip_if.device port,
    input wire logic [2:0] boot_mode,
    input wire logic core_req,
    input wire logic core_we,
    input wire logic [13:0] core_addr,
    input wire logic [15:0] core_wdata,
    output logic core_ack,
    output logic [15:0] core_rdata,
    output logic core_run,
    output logic [7:0] memory_overlay_select
);
    typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_STRETCH, ST_DONE} hip_dev_state_e;

    logic [23:0] prog_mem [2**hip_pkg::ADDR_W];
    logic [15:0] data_mem [2**hip_pkg::ADDR_W];

    hip_dev_state_e state_ff;
    logic [3:0] sync1_ff, sync2_ff, prev_ff;
    logic ack_n_ff, is_write_ff, bus_oe_ff;
    logic [15:0] bus_out_ff, hold_ff, sys_ff;
    logic [13:0] addr_ff;
    logic space_prog_ff, phase_ff;
    logic [7:0] overlay_ff;
    logic core_ack_ff, core_run_ff, boot_seen_ff;
    logic [15:0] core_rdata_ff;

    logic [3:0] raw_pins;
    logic sel_s, al_s, rd_s, wr_s;
    logic latch_evt, host_req, host_access, word_done, in_regs;
    logic host_prog_we, host_data_we, core_go, core_data_we, ctrl_we;
    logic [15:0] ctrl_word, host_rdata, bus;

    assign bus = port.host_port_shared_bus;
    assign raw_pins = {port.host_port_select_n, port.host_port_address_latch,
                       port.host_port_read_strobe_n, port.host_port_write_strobe_n};
    assign sel_s = sync2_ff[hip_pkg::PIN_SEL];
    assign al_s = sync2_ff[hip_pkg::PIN_AL];
    assign rd_s = sync2_ff[hip_pkg::PIN_RD];
    assign wr_s = sync2_ff[hip_pkg::PIN_WR];

    // strobes cross in by two flip-flops
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sync1_ff <= hip_pkg::PINS_IDLE;
            sync2_ff <= hip_pkg::PINS_IDLE;
            prev_ff <= hip_pkg::PINS_IDLE;
        end else begin
            sync1_ff <= raw_pins;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    // latch fall, or select release while latch high
    assign latch_evt = (prev_ff[hip_pkg::PIN_AL] & ~al_s)
                     | (~prev_ff[hip_pkg::PIN_SEL] & sel_s & al_s);
    assign host_req = ~sel_s & ~al_s & (~rd_s | ~wr_s);
    assign host_access = (state_ff == ST_ACCESS);
    assign word_done = ~space_prog_ff | phase_ff;
    assign in_regs = (addr_ff >= hip_pkg::REG_SPACE_BASE);

    // data writes into register space are dropped
    assign host_data_we = host_access & is_write_ff & ~space_prog_ff & ~in_regs;
    // a program word is high 16 bits then low 8
    assign host_prog_we = host_access & is_write_ff & space_prog_ff & phase_ff;

    // the core loses only the host's access cycle
    assign core_go = core_req & ~core_ack_ff & ~host_access;
    assign core_data_we = core_go & core_we & (core_addr < hip_pkg::REG_SPACE_BASE);
    // the core may load the control word too
    assign ctrl_we = latch_evt | (core_go & core_we & (core_addr == hip_pkg::CTRL_REG_ADDR));
    assign ctrl_word = latch_evt ? bus : core_wdata;

    always_comb begin
        host_rdata = 16'h0000;
        if (space_prog_ff) begin
            if (phase_ff) begin
                host_rdata = {8'h00, prog_mem[addr_ff][7:0]};
            end else begin
                host_rdata = prog_mem[addr_ff][23:8];
            end
        end else if (!in_regs) begin
            host_rdata = data_mem[addr_ff];
        end
    end

    always_ff @(posedge clock) begin
        if (host_prog_we) begin
            prog_mem[addr_ff] <= {hold_ff, bus[7:0]};
        end
        if (host_data_we) begin
            data_mem[addr_ff] <= bus;
        end else if (core_data_we) begin
            data_mem[core_addr] <= core_wdata;
        end
    end

    // address, space, half-word phase and overlay
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            addr_ff <= hip_pkg::CTRL_RESET[13:0];
            space_prog_ff <= hip_pkg::CTRL_RESET[hip_pkg::CW_SPACE_BIT];
            phase_ff <= 1'b0;
            overlay_ff <= 8'h00;
            hold_ff <= 16'h0000;
        end else if (ctrl_we) begin
            phase_ff <= 1'b0;
            if (ctrl_word[hip_pkg::CW_OVERLAY_BIT]) begin
                // overlay selection from the low byte
                overlay_ff <= ctrl_word[7:0];
            end else begin
                addr_ff <= ctrl_word[13:0];
                space_prog_ff <= (ctrl_word[hip_pkg::CW_SPACE_BIT] != hip_pkg::SPACE_DATA);
            end
        end else if (host_access) begin
            if (is_write_ff && !phase_ff) begin
                hold_ff <= bus;
            end
            // advance once the word is complete
            if (word_done) begin
                addr_ff <= addr_ff + 14'h0001;
                phase_ff <= 1'b0;
            end else begin
                phase_ff <= 1'b1;
            end
        end
    end

    // request handshake
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            ack_n_ff <= 1'b0;
            is_write_ff <= 1'b0;
            bus_oe_ff <= 1'b0;
            bus_out_ff <= 16'h0000;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    // the cycle after sync seeing the strobe
                    if (host_req) begin
                        state_ff <= ST_ACCESS;
                        // busy while the access is pending
                        ack_n_ff <= 1'b1;
                        is_write_ff <= ~wr_s;
                    end
                end
                ST_ACCESS: begin
                    if (!is_write_ff) begin
                        // only memory data leaves on the bus; register-space reads drive zero
                        bus_out_ff <= host_rdata;
                        bus_oe_ff <= 1'b1;
                    end
                    // cleared bit adds one cycle to reads
                    if (is_write_ff || sys_ff[hip_pkg::SYS_SHORT_READ_BIT]) begin
                        state_ff <= ST_DONE;
                        ack_n_ff <= 1'b0;
                    end else begin
                        state_ff <= ST_STRETCH;
                    end
                end
                ST_STRETCH: begin
                    state_ff <= ST_DONE;
                    ack_n_ff <= 1'b0;
                end
                ST_DONE: begin
                    if (rd_s && wr_s) begin
                        state_ff <= ST_IDLE;
                        bus_oe_ff <= 1'b0;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    ack_n_ff <= 1'b0;
                    bus_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    // core data-memory port; the core drops its request on seeing ack
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            core_ack_ff <= 1'b0;
            core_rdata_ff <= 16'h0000;
            sys_ff <= hip_pkg::SYS_REG_RESET;
        end else begin
            core_ack_ff <= core_go;
            if (core_go && core_we && core_addr == hip_pkg::SYS_REG_ADDR) begin
                sys_ff <= core_wdata;
            end
            if (core_go && !core_we) begin
                if (core_addr < hip_pkg::REG_SPACE_BASE) begin
                    core_rdata_ff <= data_mem[core_addr];
                end else if (core_addr == hip_pkg::CTRL_REG_ADDR) begin
                    core_rdata_ff <= {1'b0, space_prog_ff, addr_ff};
                end else if (core_addr == hip_pkg::SYS_REG_ADDR) begin
                    core_rdata_ff <= sys_ff;
                end else begin
                    core_rdata_ff <= 16'h0000;
                end
            end
        end
    end

    // straps are sampled on the first edge after reset release
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            boot_seen_ff <= 1'b0;
            core_run_ff <= 1'b0;
        end else if (!boot_seen_ff) begin
            boot_seen_ff <= 1'b1;
            // port boot keeps the core stopped
            core_run_ff <= (boot_mode != hip_pkg::BOOT_FROM_PORT);
        end else if (host_prog_we && addr_ff == 14'h0000) begin
            // program word 0 written releases the core
            core_run_ff <= 1'b1;
        end
    end

    assign port.host_port_acknowledge_n = ack_n_ff;
    assign port.dev_bus_out = bus_out_ff;
    assign port.dev_bus_oe = bus_oe_ff;
    assign core_ack = core_ack_ff;
    assign core_rdata = core_rdata_ff;
    assign core_run = core_run_ff;
    assign memory_overlay_select = overlay_ff;
endmodule

// ### hdl/hip_host.sv
// host end: apb-programmed controller that drives the memory access port
`timescale 1ns/100ps
module hip_host #(
    parameter int HOLD_CYCLES = hip_pkg::PIN_HOLD_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    hip_if.host port
);
    typedef enum logic [2:0] {
        H_IDLE, H_WAIT_READY, H_LATCH_HI, H_LATCH_LO, H_WAIT_BUSY, H_WAIT_DONE, H_RELEASE
    } hip_host_state_e;

    localparam logic [3:0] HOLD = 4'(HOLD_CYCLES);

    hip_host_state_e state_ff;
    logic [1:0] cmd_ff;
    logic [15:0] wdata_ff, rdata_ff;
    logic [3:0] cnt_ff;
    logic sel_n_ff, al_ff, rd_n_ff, wr_n_ff, oe_ff;
    logic pready_ff, pslverr_ff;
    logic [31:0] prdata_ff;
    logic busy, setup, wr_go, cmd_go, mapped, ack;

    assign ack = ~port.host_port_acknowledge_n;
    assign busy = (state_ff != H_IDLE);
    assign setup = psel & ~penable;
    assign wr_go = psel & penable & pready_ff & pwrite;
    // commands written while busy are ignored
    assign cmd_go = wr_go & (paddr == hip_pkg::HOST_CMD_OFF) & ~busy & (pwdata[1:0] != 2'h0);
    assign mapped = (paddr == hip_pkg::HOST_CMD_OFF) | (paddr == hip_pkg::HOST_WDATA_OFF)
                  | (paddr == hip_pkg::HOST_STATUS_OFF) | (paddr == hip_pkg::HOST_RDATA_OFF);

    // apb slave: one access cycle, read data captured at setup
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            wdata_ff <= 16'h0000;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup & ~mapped;
            if (setup) begin
                case (paddr)
                    hip_pkg::HOST_WDATA_OFF: prdata_ff <= {16'h0000, wdata_ff};
                    hip_pkg::HOST_STATUS_OFF: prdata_ff <= {30'h0000_0000, ack, busy};
                    hip_pkg::HOST_RDATA_OFF: prdata_ff <= {16'h0000, rdata_ff};
                    default: prdata_ff <= 32'h0000_0000;
                endcase
            end
            if (wr_go && paddr == hip_pkg::HOST_WDATA_OFF) begin
                wdata_ff <= pwdata[15:0];
            end
        end
    end

    // port sequencer
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_ff <= H_IDLE;
            cmd_ff <= 2'h0;
            cnt_ff <= 4'h0;
            rdata_ff <= 16'h0000;
            sel_n_ff <= 1'b1;
            al_ff <= 1'b0;
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
            oe_ff <= 1'b0;
        end else begin
            case (state_ff)
                H_IDLE: begin
                    if (cmd_go) begin
                        cmd_ff <= pwdata[1:0];
                        state_ff <= H_WAIT_READY;
                    end
                end
                H_WAIT_READY: begin
                    // start only once the device acknowledges
                    if (ack) begin
                        sel_n_ff <= 1'b0;
                        if (cmd_ff == hip_pkg::CMD_LATCH) begin
                            // address on the bus while acknowledged
                            al_ff <= 1'b1;
                            oe_ff <= 1'b1;
                            cnt_ff <= HOLD;
                            state_ff <= H_LATCH_HI;
                        end else begin
                            // select with the read or write strobe
                            rd_n_ff <= (cmd_ff != hip_pkg::CMD_READ);
                            wr_n_ff <= (cmd_ff != hip_pkg::CMD_WRITE);
                            oe_ff <= (cmd_ff == hip_pkg::CMD_WRITE);
                            state_ff <= H_WAIT_BUSY;
                        end
                    end
                end
                H_LATCH_HI: begin
                    if (cnt_ff == 4'h0) begin
                        al_ff <= 1'b0;
                        cnt_ff <= HOLD;
                        state_ff <= H_LATCH_LO;
                    end else begin
                        cnt_ff <= cnt_ff - 4'h1;
                    end
                end
                H_LATCH_LO: begin
                    // bus stays driven until the device has seen the fall
                    if (cnt_ff == 4'h0) begin
                        sel_n_ff <= 1'b1;
                        oe_ff <= 1'b0;
                        cnt_ff <= HOLD;
                        state_ff <= H_RELEASE;
                    end else begin
                        cnt_ff <= cnt_ff - 4'h1;
                    end
                end
                H_WAIT_BUSY: begin
                    if (!ack) begin
                        state_ff <= H_WAIT_DONE;
                    end
                end
                H_WAIT_DONE: begin
                    // acknowledge back means the access finished
                    if (ack) begin
                        if (cmd_ff == hip_pkg::CMD_READ) begin
                            rdata_ff <= port.host_port_shared_bus;
                        end
                        sel_n_ff <= 1'b1;
                        rd_n_ff <= 1'b1;
                        wr_n_ff <= 1'b1;
                        oe_ff <= 1'b0;
                        cnt_ff <= HOLD;
                        state_ff <= H_RELEASE;
                    end
                end
                H_RELEASE: begin
                    // idle gap long enough for the device to see the release
                    if (cnt_ff == 4'h0) begin
                        state_ff <= H_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 4'h1;
                    end
                end
                default: begin
                    state_ff <= H_IDLE;
                end
            endcase
        end
    end

    assign port.host_port_select_n = sel_n_ff;
    assign port.host_port_address_latch = al_ff;
    assign port.host_port_read_strobe_n = rd_n_ff;
    assign port.host_port_write_strobe_n = wr_n_ff;
    assign port.host_bus_out = wdata_ff;
    assign port.host_bus_oe = oe_ff;
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
endmodule

// ### shared/hip_if.sv
// pins between the host controller and the device's memory access port
`timescale 1ns/100ps
interface hip_if;
    logic host_port_select_n;
    logic host_port_address_latch;
    logic host_port_read_strobe_n;
    logic host_port_write_strobe_n;
    logic host_port_acknowledge_n;
    logic [15:0] host_bus_out;
    logic host_bus_oe;
    logic [15:0] dev_bus_out;
    logic dev_bus_oe;
    logic [15:0] host_port_shared_bus;

    // undriven bus floats high through the board pull-ups
    assign host_port_shared_bus = host_bus_oe ? host_bus_out :
                                  (dev_bus_oe ? dev_bus_out : 16'hffff);

    modport device (
        input host_port_select_n,
        input host_port_address_latch,
        input host_port_read_strobe_n,
        input host_port_write_strobe_n,
        input host_port_shared_bus,
        output host_port_acknowledge_n,
        output dev_bus_out,
        output dev_bus_oe
    );
    modport host (
        output host_port_select_n,
        output host_port_address_latch,
        output host_port_read_strobe_n,
        output host_port_write_strobe_n,
        output host_bus_out,
        output host_bus_oe,
        input host_port_acknowledge_n,
        input host_port_shared_bus
    );
endinterface

// ### shared/hip_pkg.sv
// constants shared by both ends of the host memory access port
package hip_pkg;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 16;
    localparam int PROG_W = 24;
    // processor data-memory addresses of the port's registers
    localparam logic [13:0] REG_SPACE_BASE = 14'h3fe0;
    localparam logic [13:0] CTRL_REG_ADDR = 14'h3fe0;
    localparam logic [13:0] SYS_REG_ADDR = 14'h3fe7;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] SYS_REG_RESET = 16'h0000;
    // control word and system register layout
    localparam int CW_OVERLAY_BIT = 15;
    localparam int CW_SPACE_BIT = 14;
    localparam int SYS_SHORT_READ_BIT = 14;
    localparam logic SPACE_DATA = 1'b0;
    // boot mode straps {c, b, a}
    localparam logic [2:0] BOOT_FROM_PORT = 3'h5;
    // synchroniser bit positions and idle levels {select_n, latch, read_n, write_n}
    localparam int PIN_SEL = 3;
    localparam int PIN_AL = 2;
    localparam int PIN_RD = 1;
    localparam int PIN_WR = 0;
    localparam logic [3:0] PINS_IDLE = 4'hb;
    // host controller apb map
    localparam logic [11:0] HOST_CMD_OFF = 12'h000;
    localparam logic [11:0] HOST_WDATA_OFF = 12'h004;
    localparam logic [11:0] HOST_STATUS_OFF = 12'h008;
    localparam logic [11:0] HOST_RDATA_OFF = 12'h00c;
    localparam logic [1:0] CMD_LATCH = 2'h1;
    localparam logic [1:0] CMD_WRITE = 2'h2;
    localparam logic [1:0] CMD_READ = 2'h3;
    // least hold of a host pin level, in ns and in cycles
    localparam int CLK_PERIOD_NS = 20;
    localparam int PIN_HOLD_NS = 80;
    localparam int PIN_HOLD_CYCLES = (PIN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
